// file: logic/pwr_event_map.svh
// Constants for the power-event and wake control block.
// Assumes inclusion by bare name from the package and design files.
`ifndef PWR_EVENT_MAP_SVH
`define PWR_EVENT_MAP_SVH

`define ADR_PEC          8'hD4
`define ADR_SWT          8'hD6
`define ADR_IRQ_STATUS   8'hE8
`define ADR_IRQ_CLEAR    8'hEC
`define ADR_IRQ_ENABLE   8'hF0
`define ADR_MODE_STATUS  8'hF4
`define ADR_GRR_READ     8'hF8

`define PEC_DELAY_EN     14
`define PEC_POLARITY     12
`define PEC_OUT_EN_HI    11
`define PEC_OUT_EN_LO    8
`define PEC_AUTO_WAKE    7
`define PEC_WAKE_NORMAL  6
`define PEC_IND_HI       5
`define PEC_IND_LO       2
`define PEC_MODE_HI      1
`define PEC_MODE_LO      0
`define PEC_RW_MASK      16'h5FC3

`define MODE_NORMAL      2'h0
`define MODE_ENERGY      2'h1
`define MODE_SOFT_PD     2'h2
`define MODE_SAVING      2'h3

`define EV_ENERGY        0
`define EV_LINK          1
`define EV_MAGIC         2
`define EV_FRAME         3

`define ISR_ENERGY_BIT   2
`define ISR_LINK_BIT     3

`define WAKE_TIME_DEF    8'h08
`define SLEEP_TIME_DEF   8'h0C
`define WAKE_UNIT_MS     16
`define SLEEP_UNIT_MS    1000
`define CLK_MHZ          200
`define READY_CYCLES     8'h10

`endif

// file: logic/pwr_event_pkg.sv
// Types for the power-event and wake control block.
// Assumes pwr_event_map.svh on the include path.
`include "pwr_event_map.svh"
package pwr_event_pkg;
	typedef enum logic [2:0] {
		ST_NORMAL = 3'h1,
		ST_LOW    = 3'h2,
		ST_WAKING = 3'h4
	} energy_state_t;

	typedef struct packed {
		logic       cyc;
		logic       stb;
		logic       we;
		logic [7:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} wb_req_t;

	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} wb_rsp_t;

	typedef struct packed {
		logic [3:0] pulse;
	} wake_events_t;
endpackage

// file: logic/pin_sync.sv
// Three-stage synchroniser for an input from outside the clock domain.
// Assumes one clock; the output changes once stages two and three agree.
`timescale 1ns/1ps
module pin_sync (
	input  wire logic core_clk,
	input  wire logic reset,
	input  wire logic pin_in,
	output logic      level
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic lv;
	} sync_state_t;

	sync_state_t st_reg;
	sync_state_t st_next;

	always_comb begin
		st_next    = st_reg;
		st_next.s1 = pin_in;
		st_next.s2 = st_reg.s1;
		st_next.s3 = st_reg.s2;
		if (st_reg.s2 == st_reg.s3) begin
			st_next.lv = st_reg.s3;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign level = st_reg.lv;
endmodule

// file: logic/power_event_wake_control.sv
// Power-event control register, wake-event latching, wake output and energy-detect sequencing.
// Assumes event detectors give one-cycle pulses on core_clk and energy_present is an async level.
// Behaviour
// RL1: Delay-enable holds output until clocks ready.
// RL2: Delay off asserts at once; needs auto-wake.
// RL3: Polarity bit one high, zero low.
// RL4: Enables 11..8: frame, magic, link, energy.
// RL5: Only enabled events assert the output.
// RL6: Auto-wake leaves low power after wake time.
// RL7: Normal-power state allows receive and transmit.
// RL8: Wake-to-normal bit returns mode to normal.
// RL9: Indication field one-hot per event kind.
// RL10: Energy sets status bit 2, link bit 3.
// RL11: Indications clear on power-up or write-one.
// RL12: Cleared indications deassert the output.
// RL13: Mode 00 normal, 01 energy detect.
// RL14: 10 soft power-down, 11 saving; global read wakes. Code wakes soft power-down and energy-detect low only, not saving.
// RL15: Wake time eight bits, 16 ms units.
// RL16: Sleep time eight bits, 1 s units.
// RL17: Indications sticky; output held while enabled.
//
// The Wishbone slave port was left to the implementer.
`timescale 1ns/1ps
`include "pwr_event_map.svh"
module power_event_wake_control #(
	parameter int unsigned WAKE_UNIT_CYCLES  = `WAKE_UNIT_MS * `CLK_MHZ * 1000,
	parameter int unsigned SLEEP_UNIT_CYCLES = `SLEEP_UNIT_MS * `CLK_MHZ * 1000
) (
	input  wire logic                      core_clk,
	input  wire logic                      reset,
	input  wire logic                      power_up_reset,
	input  wire pwr_event_pkg::wb_req_t    wb_req,
	output pwr_event_pkg::wb_rsp_t         wb_rsp,
	input  wire pwr_event_pkg::wake_events_t wake_events,
	input  wire logic                      energy_present,
	input  wire logic                      clocks_ready,
	output logic                           wake_event_output,
	output logic                           rx_tx_enable,
	output logic                           low_power,
	output logic                           soft_power_down,
	output logic                           irq
);

	////////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic [15:0]                  pec;
		logic [3:0]                   ind;
		logic [15:0]                  swt;
		logic [3:0]                   irq_stat;
		logic [3:0]                   irq_en;
		pwr_event_pkg::energy_state_t est;
		logic [31:0]                  unit_cnt;
		logic [7:0]                   unit_num;
		logic                         pd_wake;
		logic                         ack;
		logic [31:0]                  rdat;
		logic                         out_act;
	} state_t;

	state_t st_reg;
	state_t st_next;
	logic   energy_lv;

	pin_sync u_energy_sync (
		.core_clk (core_clk),
		.reset    (reset),
		.pin_in   (energy_present),
		.level    (energy_lv)
	);

	function automatic logic hit(input logic [7:0] adr, input logic [7:0] want);
		hit = adr == want;
	endfunction

	logic       access;
	logic       wr;
	logic [1:0] mode;
	logic       auto_wake;
	logic [3:0] new_ind;
	logic       delay_ok;

	assign access    = wb_req.cyc && wb_req.stb && !st_reg.ack;
	assign wr        = access && wb_req.we;
	assign mode      = st_reg.pec[`PEC_MODE_HI:`PEC_MODE_LO]; // RL13 RL14
	assign auto_wake = st_reg.pec[`PEC_AUTO_WAKE];
	assign new_ind   = wake_events.pulse; // RL9

	// Only the delayed path waits; it applies only with auto-wake set.
	assign delay_ok = !(st_reg.pec[`PEC_DELAY_EN] && auto_wake) || clocks_ready; // RL1 RL2

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		logic [3:0] clr;
		logic       run;
		logic [7:0] limit;
		clr      = 4'h0;
		run      = 1'b0;
		limit    = 8'h00;
		st_next  = st_reg;
		st_next.ack = access;
		st_next.rdat = 32'h0000_0000;

		if (access && !wb_req.we) begin
			unique case (1'b1)
				hit(wb_req.adr, `ADR_PEC):         st_next.rdat = {16'h0000, st_reg.pec[15:6], st_reg.ind,
					st_reg.pec[1:0]};
				hit(wb_req.adr, `ADR_SWT):         st_next.rdat = {16'h0000, st_reg.swt};
				hit(wb_req.adr, `ADR_IRQ_STATUS):  st_next.rdat = {28'h0000000, st_reg.irq_stat};
				hit(wb_req.adr, `ADR_IRQ_ENABLE):  st_next.rdat = {28'h0000000, st_reg.irq_en};
				hit(wb_req.adr, `ADR_MODE_STATUS): st_next.rdat = {29'h00000000, st_reg.est};
				hit(wb_req.adr, `ADR_GRR_READ):    st_next.pd_wake = 1'b1; // RL14
				default:                           st_next.rdat = 32'h0000_0000;
			endcase
		end

		if (wr && wb_req.sel[0] && wb_req.sel[1]) begin
			if (hit(wb_req.adr, `ADR_PEC)) begin
				st_next.pec = wb_req.dat[15:0] & `PEC_RW_MASK;
				clr = wb_req.dat[`PEC_IND_HI:`PEC_IND_LO]; // RL11
			end
			// Zero is not a legal time; such a write is ignored.
			if (hit(wb_req.adr, `ADR_SWT) && wb_req.dat[15:8] != 8'h00 && wb_req.dat[7:0] != 8'h00) begin
				st_next.swt = wb_req.dat[15:0]; // RL15 RL16
			end
		end
		if (wr && wb_req.sel[0]) begin
			if (hit(wb_req.adr, `ADR_IRQ_ENABLE)) begin
				st_next.irq_en = wb_req.dat[3:0];
			end
		end

		// Set wins over clear so an event in the clearing cycle is kept.
		st_next.ind = (st_reg.ind & ~clr) | new_ind; // RL17 RL11
		if (wr && wb_req.sel[0] && hit(wb_req.adr, `ADR_IRQ_CLEAR)) begin
			st_next.irq_stat = st_reg.irq_stat & ~wb_req.dat[3:0];
		end
		st_next.irq_stat[`ISR_ENERGY_BIT] = st_next.irq_stat[`ISR_ENERGY_BIT] | new_ind[`EV_ENERGY]; // RL10
		st_next.irq_stat[`ISR_LINK_BIT]   = st_next.irq_stat[`ISR_LINK_BIT] | new_ind[`EV_LINK]; // RL10
		st_next.irq_stat[0] = st_next.irq_stat[0] | new_ind[`EV_MAGIC];
		st_next.irq_stat[1] = st_next.irq_stat[1] | new_ind[`EV_FRAME];

		st_next.out_act = |(st_next.ind & st_reg.pec[`PEC_OUT_EN_HI:`PEC_OUT_EN_LO]); // RL4 RL5 RL12 RL17

		// Energy-detect sequencing between low and normal power.
		if (mode == `MODE_ENERGY) begin
			unique case (st_reg.est)
				pwr_event_pkg::ST_NORMAL: begin
					run   = !energy_lv;
					limit = st_reg.swt[7:0]; // RL16
					if (run && st_reg.unit_num == limit) begin
						st_next.est = pwr_event_pkg::ST_LOW;
						run = 1'b0;
					end
				end
				pwr_event_pkg::ST_LOW: begin
					if (st_reg.pd_wake) begin
						st_next.est = pwr_event_pkg::ST_NORMAL;
					end else if (energy_lv && auto_wake) begin // RL6
						st_next.est = pwr_event_pkg::ST_WAKING;
					end
				end
				pwr_event_pkg::ST_WAKING: begin
					run   = energy_lv;
					limit = st_reg.swt[15:8]; // RL15
					if (!energy_lv || !auto_wake) begin
						st_next.est = pwr_event_pkg::ST_LOW;
					end else if (st_reg.unit_num == limit) begin
						st_next.est = pwr_event_pkg::ST_NORMAL; // RL6 RL7
						run = 1'b0;
						if (st_reg.pec[`PEC_WAKE_NORMAL]) begin
							st_next.pec[`PEC_MODE_HI:`PEC_MODE_LO] = `MODE_NORMAL; // RL8
						end
					end
				end
			endcase
		end else begin
			st_next.est = pwr_event_pkg::ST_NORMAL;
		end
		if (mode == `MODE_SOFT_PD && st_reg.pd_wake) begin
			st_next.pec[`PEC_MODE_HI:`PEC_MODE_LO] = `MODE_NORMAL; // RL14
		end
		if (st_reg.pd_wake) begin
			st_next.pd_wake = 1'b0;
		end

		// Units counted in cycles, then in programmed units.
		if (run && st_next.est == st_reg.est) begin
			if (st_reg.unit_cnt >= ((st_reg.est == pwr_event_pkg::ST_WAKING) ? WAKE_UNIT_CYCLES : SLEEP_UNIT_CYCLES) - 1)
				begin
				st_next.unit_cnt = 32'h0000_0000;
				st_next.unit_num = st_reg.unit_num + 8'h01;
			end else begin
				st_next.unit_cnt = st_reg.unit_cnt + 32'h0000_0001;
			end
		end else begin
			st_next.unit_cnt = 32'h0000_0000;
			st_next.unit_num = 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge core_clk) begin
		if (reset || power_up_reset) begin
			st_reg.pec      <= 16'h0000;
			st_reg.swt      <= {`WAKE_TIME_DEF, `SLEEP_TIME_DEF};
			st_reg.irq_stat <= 4'h0;
			st_reg.irq_en   <= 4'h0;
			st_reg.est      <= pwr_event_pkg::ST_NORMAL;
			st_reg.unit_cnt <= 32'h0000_0000;
			st_reg.unit_num <= 8'h00;
			st_reg.pd_wake  <= 1'b0;
			st_reg.ack      <= 1'b0;
			st_reg.rdat     <= 32'h0000_0000;
		end else begin
			st_reg.pec      <= st_next.pec;
			st_reg.swt      <= st_next.swt;
			st_reg.irq_stat <= st_next.irq_stat;
			st_reg.irq_en   <= st_next.irq_en;
			st_reg.est      <= st_next.est;
			st_reg.unit_cnt <= st_next.unit_cnt;
			st_reg.unit_num <= st_next.unit_num;
			st_reg.pd_wake  <= st_next.pd_wake;
			st_reg.ack      <= st_next.ack;
			st_reg.rdat     <= st_next.rdat;
		end
		// Indications survive the ordinary reset; of the two resets only power-up clears them.
		if (power_up_reset) begin
			st_reg.ind     <= 4'h0; // RL11
			st_reg.out_act <= 1'b0;
		end else begin
			st_reg.ind     <= st_next.ind;
			st_reg.out_act <= st_next.out_act;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	logic active;
	assign active            = st_reg.out_act && delay_ok; // RL1 RL2
	assign wake_event_output = st_reg.pec[`PEC_POLARITY] ? active : !active; // RL3
	assign rx_tx_enable      = st_reg.est == pwr_event_pkg::ST_NORMAL && mode != `MODE_SOFT_PD; // RL7
	assign low_power         = st_reg.est != pwr_event_pkg::ST_NORMAL || mode == `MODE_SAVING;
	assign soft_power_down   = mode == `MODE_SOFT_PD; // RL14
	assign irq               = |(st_reg.irq_stat & st_reg.irq_en);
	assign wb_rsp.ack        = st_reg.ack;
	assign wb_rsp.dat        = st_reg.rdat;

	////////////////////////////////////////////////////////////////////////////
	sequence ev_energy_s;
		wake_events.pulse[`EV_ENERGY] && !power_up_reset;
	endsequence

	ind_sticky_a: assert property (@(posedge core_clk) disable iff (reset || power_up_reset) // RL17
		ev_energy_s |=> st_reg.ind[`EV_ENERGY]) else $error("energy indication not latched");
	isr_energy_a: assert property (@(posedge core_clk) disable iff (reset || power_up_reset) // RL10
		ev_energy_s |=> st_reg.irq_stat[`ISR_ENERGY_BIT]) else $error("status bit 2 not set");
	isr_link_a: assert property (@(posedge core_clk) disable iff (reset || power_up_reset) // RL10
		wake_events.pulse[`EV_LINK] |=> st_reg.irq_stat[`ISR_LINK_BIT]) else $error("status bit 3 not set");
	out_gate_a: assert property (@(posedge core_clk) disable iff (reset || power_up_reset) // RL5
		st_reg.out_act == |(st_reg.ind & $past(st_reg.pec[`PEC_OUT_EN_HI:`PEC_OUT_EN_LO])))
		else $error("output not gated by enables");
	out_polarity_a: assert property (@(posedge core_clk) disable iff (reset) // RL3
		active |-> wake_event_output == st_reg.pec[`PEC_POLARITY]) else $error("wrong output polarity");
	delay_hold_a: assert property (@(posedge core_clk) disable iff (reset) // RL1
		(st_reg.pec[`PEC_DELAY_EN] && auto_wake && !clocks_ready) |-> !active) else $error("output not delayed");
	no_delay_a: assert property (@(posedge core_clk) disable iff (reset) // RL2
		(!st_reg.pec[`PEC_DELAY_EN] && st_reg.out_act) |-> active) else $error("output delayed without enable");
	clear_deassert_a: assert property (@(posedge core_clk) disable iff (reset || power_up_reset) // RL12
		(st_reg.ind == 4'h0) |=> !st_reg.out_act || $past(new_ind) != 4'h0) else $error("output held after clear");
	no_auto_a: assert property (@(posedge core_clk) disable iff (reset) // RL6
		(st_reg.est == pwr_event_pkg::ST_LOW && !auto_wake && !st_reg.pd_wake) |=>
		st_reg.est != pwr_event_pkg::ST_WAKING) else $error("woke without auto wake");
	ack_once_a: assert property (@(posedge core_clk) disable iff (reset) // Wishbone ack
		wb_rsp.ack |=> !wb_rsp.ack) else $error("ack longer than one cycle");

	// A write of one to an indication bit clears it unless the same event arrives in that cycle.
	ind_w1c_a: assert property (@(posedge core_clk) disable iff (reset || power_up_reset) // RL11
		(wr && wb_req.sel[0] && wb_req.sel[1] && hit(wb_req.adr, `ADR_PEC) && wb_req.dat[`PEC_IND_LO]
		&& !new_ind[`EV_ENERGY]) |=> !st_reg.ind[`EV_ENERGY]) else $error("indication not cleared by write");
	wake_normal_a: assert property (@(posedge core_clk) disable iff (reset || power_up_reset) // RL8
		(mode == `MODE_ENERGY && st_reg.est == pwr_event_pkg::ST_WAKING && st_next.est == pwr_event_pkg::ST_NORMAL
		&& st_reg.pec[`PEC_WAKE_NORMAL]) |=> mode == `MODE_NORMAL) else $error("mode not returned to normal");
endmodule

// file: verification/host_wake_model.sv
// Host-side wake logic that watches the wake-event pin of the block.
// Assumes the bench tells it the polarity that software programmed.
`timescale 1ns/1ps
module host_wake_model (
	input  wire logic core_clk,
	input  wire logic wake_pin,
	input  wire logic active_high,
	output logic      woken
);
	// Registered so the host decision never races the pin's own update.
	always_ff @(posedge core_clk) begin
		woken <= (wake_pin == active_high);
	end
endmodule

// file: verification/tb.sv
// Self-checking bench for the power-event and wake control block.
// Assumes pwr_event_pkg and host_wake_model are compiled before it.
`timescale 1ns/1ps
module tb;
	logic                        core_clk;
	logic                        reset;
	logic                        power_up_reset;
	pwr_event_pkg::wb_req_t      req;
	pwr_event_pkg::wb_rsp_t      rsp;
	pwr_event_pkg::wake_events_t ev;
	logic                        energy_present;
	logic                        clocks_ready;
	logic                        wake_pin;
	logic                        rx_tx_enable;
	logic                        low_power;
	logic                        soft_power_down;
	logic                        irq;
	logic                        pol;
	logic                        woken;
	logic [15:0]                 q;
	logic [15:0]                 ctl;
	int                          n_mismatch;
	int                          compares;
	int                          seed;
	int                          isr_bit [4] = '{2, 3, 0, 1};

	// Short units keep the sleep and wake counts to a few dozen cycles.
	power_event_wake_control #(.WAKE_UNIT_CYCLES(4), .SLEEP_UNIT_CYCLES(8)) dut_u (
		.core_clk(core_clk), .reset(reset), .power_up_reset(power_up_reset),
		.wb_req(req), .wb_rsp(rsp), .wake_events(ev), .energy_present(energy_present),
		.clocks_ready(clocks_ready), .wake_event_output(wake_pin), .rx_tx_enable(rx_tx_enable),
		.low_power(low_power), .soft_power_down(soft_power_down), .irq(irq));
	host_wake_model host_u (.core_clk(core_clk), .wake_pin(wake_pin), .active_high(pol), .woken(woken));

	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	////////////////////////////////////////////////////////////////
	task automatic report_and_stop;
		if (n_mismatch == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Entered just after a rising edge; returns just after one, bus idle.
	task automatic wb(input logic we, input logic [7:0] a, input logic [15:0] d);
		int n;
		n = 0;
		req.cyc <= 1'b1;
		req.stb <= 1'b1;
		req.we <= we;
		req.adr <= a;
		req.sel <= 4'h3;
		req.dat <= {16'h0000, d};
		// Acknowledge and read data are sampled at the edge itself, before the design updates them.
		do begin
			@(posedge core_clk);
			n++;
		end while (rsp.ack !== 1'b1 && n < 50);
		if (rsp.ack !== 1'b1) begin
			n_mismatch++;
			$display("unexpected at %0t: no acknowledge", $time);
		end
		q = rsp.dat[15:0];
		req.cyc <= 1'b0;
		req.stb <= 1'b0;
		@(posedge core_clk);
	endtask

	task automatic pulse(input int k);
		ev.pulse[k] <= 1'b1;
		@(posedge core_clk);
		ev.pulse <= 4'h0;
		repeat (4) @(posedge core_clk);
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge core_clk);
		n_mismatch++;
		report_and_stop();
	end

	initial begin
		seed = 58;
		n_mismatch = 0;
		compares = 0;
		reset = 1'b1;
		power_up_reset = 1'b1;
		req = '0;
		ev = '0;
		energy_present = 1'b1;
		clocks_ready = 1'b1;
		pol = 1'b0;
		repeat (5) @(posedge core_clk);
		reset <= 1'b0;
		power_up_reset <= 1'b0;
		@(posedge core_clk);
		wb(0, 8'hD4, 16'h0000); chk(q, 16'h0000);
		wb(0, 8'hD6, 16'h0000); chk(q, 16'h080C);
		chk(16'(woken), 16'h0000);
		wb(1, 8'hA0, 16'hFFFF);
		wb(0, 8'hA0, 16'h0000); chk(q, 16'h0000);
		wb(1, 8'hF0, 16'h000F);
		for (int k = 0; k < 4; k++) begin
			pol = 1'($random(seed));
			ctl = {3'h0, pol, 12'h000} | (16'h0100 << k);
			wb(1, 8'hD4, ctl);
			pulse(k);
			repeat (16) @(posedge core_clk);
			wb(0, 8'hD4, 16'h0000); chk(q, ctl | (16'h0004 << k));
			chk(16'(woken), 16'h0001);
			chk(16'(irq), 16'h0001);
			wb(0, 8'hE8, 16'h0000); chk(q, 16'h0001 << isr_bit[k]);
			wb(1, 8'hF0, 16'h0000); chk(16'(irq), 16'h0000);
			wb(1, 8'hF0, 16'h000F);
			wb(1, 8'hD4, ctl | (16'h0004 << k));
			repeat (2) @(posedge core_clk);
			chk(16'(woken), 16'h0000);
			wb(1, 8'hEC, 16'h000F); chk(16'(irq), 16'h0000);
			ctl = {3'h0, pol, 12'h000} | (~(16'h0100 << k) & 16'h0F00);
			wb(1, 8'hD4, ctl);
			pulse(k);
			chk(16'(woken), 16'h0000);
			wb(1, 8'hD4, ctl | 16'h003C);
			wb(1, 8'hEC, 16'h000F);
		end
		pol = 1'b1;
		wb(1, 8'hD4, 16'h1800);
		pulse(3);
		reset <= 1'b1;
		repeat (2) @(posedge core_clk);
		reset <= 1'b0;
		@(posedge core_clk);
		wb(0, 8'hD4, 16'h0000); chk(q, 16'h0020);
		power_up_reset <= 1'b1;
		repeat (2) @(posedge core_clk);
		power_up_reset <= 1'b0;
		@(posedge core_clk);
		wb(0, 8'hD4, 16'h0000); chk(q, 16'h0000);
		clocks_ready <= 1'b0;
		wb(1, 8'hD4, 16'h5180);
		pulse(0);
		chk(16'(woken), 16'h0000);
		clocks_ready <= 1'b1;
		repeat (4) @(posedge core_clk);
		chk(16'(woken), 16'h0001);
		wb(1, 8'hD4, 16'h5184);
		clocks_ready <= 1'b0;
		wb(1, 8'hD4, 16'h5100);
		pulse(0);
		chk(16'(woken), 16'h0001);
		wb(1, 8'hD4, 16'h5104);
		clocks_ready <= 1'b1;
		for (int m = 0; m < 4; m++) begin
			wb(1, 8'hD4, 16'(m));
			wb(0, 8'hD4, 16'h0000); chk(q, 16'(m));
			if (m == 2) begin
				chk(16'(soft_power_down), 16'h0001);
				wb(0, 8'hF8, 16'h0000);
				repeat (2) @(posedge core_clk);
				chk(16'(soft_power_down), 16'h0000);
			end
		end
		wb(1, 8'hD6, 16'h0203);
		wb(1, 8'hD6, 16'h0005);
		wb(0, 8'hD6, 16'h0000); chk(q, 16'h0203);
		energy_present <= 1'b0;
		wb(1, 8'hD4, 16'h0001);
		repeat (60) @(posedge core_clk);
		chk(16'(low_power), 16'h0001);
		energy_present <= 1'b1;
		repeat (40) @(posedge core_clk);
		chk(16'(low_power), 16'h0001);
		wb(0, 8'hF8, 16'h0000);
		repeat (4) @(posedge core_clk);
		chk(16'(low_power), 16'h0000);
		energy_present <= 1'b0;
		wb(1, 8'hD4, 16'h00C1);
		repeat (60) @(posedge core_clk);
		chk(16'(low_power), 16'h0001);
		energy_present <= 1'b1;
		repeat (40) @(posedge core_clk);
		chk(16'(low_power), 16'h0000);
		chk(16'(rx_tx_enable), 16'h0001);
		wb(0, 8'hD4, 16'h0000); chk(q, 16'h00C0);
		report_and_stop();
	end
endmodule
